/* File: verilog/rpt_cfg.svh */
// rpt_cfg.svh: offsets, fields, reset values and timing counts of the polling timebase
// assumes: included by bare name; clk_sys is the crystal-derived clock at 50 MHz
`ifndef RPT_CFG_SVH
`define RPT_CFG_SVH
`define RPT_CLK_MHZ 50
`define RPT_TICK_DIV 16
`define RPT_SLEEP_UNIT 1024
// start-up figures: synthesizer in tenths of a basic tick, signal processing per range in basic ticks
`define RPT_PLL_START_X10 7985
`define RPT_SIG_START_R0 930
`define RPT_SIG_START_R1 546
`define RPT_SIG_START_R2 354
`define RPT_SIG_START_R3 258
// edge-to-edge limits of range 0 in microseconds
`define RPT_TEE_MIN_US 200
`define RPT_TEE_MAX_US 500
// basic ticks per extended tick of range 0 at limit-select 0
`define RPT_XT_BASE 8
// register byte offsets
`define RPT_OFS_CTRL 4'h0
`define RPT_OFS_SLEEP 4'h4
`define RPT_OFS_STATUS 4'h8
// control fields
`define RPT_CTRL_EN 0
`define RPT_CTRL_RANGE_LO 1
`define RPT_CTRL_EXTENDED_LIMIT_SELECT 3
`define RPT_CTRL_NCHK_LO 4
`define RPT_CTRL_RST 32'h0000_0000
`define RPT_SLEEP_RST 32'h0000_0101
`endif

/* File: verilog/rpt_pkg.sv */
// rpt_pkg: types shared by the polling timebase modules
// assumes: nothing beyond the compiler
package rpt_pkg;
	typedef enum logic [2:0] {
		RPT_IDLE,
		RPT_SLEEP,
		RPT_PLL,
		RPT_SIGPROC,
		RPT_CHECK,
		RPT_RECEIVE
	} rpt_state_t;
endpackage

/* File: verilog/rpt_tick_gen.sv */
// rpt_tick_gen: basic tick, half tick and extended tick strobes
// assumes: clk_sys is the crystal clock; range and limit select may change at any time
`timescale 1ns/10ps
`include "rpt_cfg.svh"
module rpt_tick_gen #(
	parameter int TICK_DIV = `RPT_TICK_DIV
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [1:0] bit_rate_range,
	input wire logic extended_limit_select,
	output logic tick,
	output logic half_tick,
	output logic ext_tick
);
	logic [15:0] div_reg;
	logic [4:0] xcnt_reg;
	logic [4:0] xdiv;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_reg <= 16'h0000;
			tick <= 1'b0;
			half_tick <= 1'b0;
		end else begin
			tick <= (div_reg == 16'(TICK_DIV - 1));
			half_tick <= (div_reg == 16'(TICK_DIV - 1)) || (div_reg == 16'(TICK_DIV / 2 - 1));
			div_reg <= (div_reg == 16'(TICK_DIV - 1)) ? 16'h0000 : div_reg + 16'h0001;
		end
	end

	assign xdiv = extended_limit_select ? (5'd16 >> bit_rate_range) : (5'd8 >> bit_rate_range);

	// counts basic ticks; a shrinking divisor wraps at once instead of running long
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			xcnt_reg <= 5'h00;
			ext_tick <= 1'b0;
		end else begin
			ext_tick <= 1'b0;
			if (tick) begin
				if (xcnt_reg + 5'h01 >= xdiv) begin
					xcnt_reg <= 5'h00;
					ext_tick <= 1'b1;
				end else begin
					xcnt_reg <= xcnt_reg + 5'h01;
				end
			end
		end
	end
endmodule

/* File: verilog/rpt_bit_check.sv */
// rpt_bit_check: edge-to-edge check of the demodulated data during polling
// assumes: data_in synchronous to clk_sys; start is a one-cycle pulse while idle
`timescale 1ns/10ps
module rpt_bit_check (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic ext_tick,
	input wire logic data_in,
	input wire logic [4:0] need_edges,
	input wire logic [7:0] lim_min,
	input wire logic [7:0] lim_max,
	output logic done,
	output logic pass
);
	logic busy_reg;
	logic seen_reg;
	logic prev_reg;
	logic [7:0] cnt_reg;
	logic [4:0] good_reg;
	logic edge_hit;

	assign edge_hit = data_in ^ prev_reg;

	// edge history for the detector
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= data_in;
		end
	end

	// interval check, fails fast on noise
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
			seen_reg <= 1'b0;
			cnt_reg <= 8'h00;
			good_reg <= 5'h00;
			done <= 1'b0;
			pass <= 1'b0;
		end else begin
			done <= 1'b0;
			pass <= 1'b0;
			if (start) begin
				// zero count means no check: pass at once
				busy_reg <= (need_edges != 5'h00);
				done <= (need_edges == 5'h00);
				pass <= (need_edges == 5'h00);
				seen_reg <= 1'b0;
				cnt_reg <= 8'h00;
				good_reg <= 5'h00;
			end else if (busy_reg) begin
				if (edge_hit) begin
					cnt_reg <= 8'h00;
					seen_reg <= 1'b1;
					if (seen_reg && cnt_reg < lim_min) begin
						busy_reg <= 1'b0;
						done <= 1'b1;
					end else if (seen_reg) begin
						good_reg <= good_reg + 5'h01;
						if (good_reg + 5'h01 == need_edges) begin
							busy_reg <= 1'b0;
							done <= 1'b1;
							pass <= 1'b1;
						end
					end
				end else if (ext_tick) begin
					if (cnt_reg >= lim_max) begin
						busy_reg <= 1'b0;
						done <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg + 8'h01;
					end
				end
			end
		end
	end
endmodule

/* File: verilog/rpt_top.sv */
// rpt_top: receive-polling timebase with a classic Wishbone register slave
// assumes: one clock clk_sys from the crystal; data_in already sliced and synchronous
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "rpt_cfg.svh"
module rpt_top
	import rpt_pkg::*;
#(
	parameter int TICK_DIV = `RPT_TICK_DIV,
	parameter int SLEEP_UNIT = `RPT_SLEEP_UNIT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic data_in,
	output logic synth_enable,
	output logic sigproc_enable,
	output logic check_active,
	output logic signal_found
);
	////////////////////////////////////////////////////////////////////////
	// constants derived from the timing figures

	// half ticks, so the .5 of the synthesizer start-up is exact
	localparam logic [15:0] PLL_HALF = 16'(`RPT_PLL_START_X10 * 2 / 10);
	localparam logic [15:0] SIG_HALF0 = 16'(`RPT_SIG_START_R0 * 2);
	localparam logic [15:0] SIG_HALF1 = 16'(`RPT_SIG_START_R1 * 2);
	localparam logic [15:0] SIG_HALF2 = 16'(`RPT_SIG_START_R2 * 2);
	localparam logic [15:0] SIG_HALF3 = 16'(`RPT_SIG_START_R3 * 2);
	// limits in extended ticks of range 0; same for all ranges since both scale
	localparam int TICK_NS = 1000 * `RPT_TICK_DIV / `RPT_CLK_MHZ;
	localparam int XT_NS = TICK_NS * `RPT_XT_BASE;
	localparam logic [7:0] XT_MIN = 8'((`RPT_TEE_MIN_US * 1000 + XT_NS - 1) / XT_NS);
	localparam logic [7:0] XT_MAX = 8'((`RPT_TEE_MAX_US * 1000) / XT_NS);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [31:0] ctrl_reg;
	logic [31:0] sleep_reg;
	logic poll_en;
	logic [1:0] bit_rate_range;
	logic extended_limit_select;
	logic [1:0] nchk_sel;
	logic [7:0] sleep_value;
	logic [7:0] idle_extension_factor;
	logic wb_req;

	assign poll_en = ctrl_reg[`RPT_CTRL_EN];
	assign bit_rate_range = ctrl_reg[`RPT_CTRL_RANGE_LO +: 2];
	assign extended_limit_select = ctrl_reg[`RPT_CTRL_EXTENDED_LIMIT_SELECT];
	assign nchk_sel = ctrl_reg[`RPT_CTRL_NCHK_LO +: 2];
	assign sleep_value = sleep_reg[7:0];
	assign idle_extension_factor = sleep_reg[15:8];
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	////////////////////////////////////////////////////////////////////////
	// tick generation and bit check

	logic tick;
	logic half_tick;
	logic ext_tick;
	logic chk_start;
	logic chk_done;
	logic chk_pass;
	logic [4:0] need_edges;
	logic [7:0] lim_min;
	logic [7:0] lim_max;

	rpt_tick_gen #(
		.TICK_DIV(TICK_DIV)
	) u_tick (
		.clk_sys(clk_sys),
		.rst(rst),
		.bit_rate_range(bit_rate_range),
		.extended_limit_select(extended_limit_select),
		.tick(tick),
		.half_tick(half_tick),
		.ext_tick(ext_tick)
	);

	// two edges per period, so N periods need 2N intervals
	always_comb begin
		case (nchk_sel)
			2'h0: need_edges = 5'h00;
			2'h1: need_edges = 5'h06;
			2'h2: need_edges = 5'h0C;
			default: need_edges = 5'h12;
		endcase
	end

	// range limits; a longer extended tick halves the count
	always_comb begin
		if (extended_limit_select) begin
			lim_min = XT_MIN >> 1;
			lim_max = XT_MAX >> 1;
		end else begin
			lim_min = XT_MIN;
			lim_max = XT_MAX;
		end
	end

	rpt_bit_check u_chk (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(chk_start),
		.ext_tick(ext_tick),
		.data_in(data_in),
		.need_edges(need_edges),
		.lim_min(lim_min),
		.lim_max(lim_max),
		.done(chk_done),
		.pass(chk_pass)
	);

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, every address answered

	// register writes honour byte lanes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `RPT_CTRL_RST;
			sleep_reg <= `RPT_SLEEP_RST;
		end else if (wb_req && wb_we_i) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i] && wb_adr_i == `RPT_OFS_CTRL) begin
					ctrl_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8] & (i == 0 ? 8'h3F : 8'h00);
				end
				if (wb_sel_i[i] && wb_adr_i == `RPT_OFS_SLEEP) begin
					sleep_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8] & (i < 2 ? 8'hFF : 8'h00);
				end
			end
		end
	end

	rpt_state_t state_reg;
	rpt_state_t state_next;
	logic found_reg;

	// ack and read data; unmapped offsets read zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`RPT_OFS_CTRL: wb_dat_o <= ctrl_reg;
					`RPT_OFS_SLEEP: wb_dat_o <= sleep_reg;
					`RPT_OFS_STATUS: wb_dat_o <= {27'h0, found_reg, 1'b0, state_reg};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// polling sequencer

	logic [31:0] cnt_reg;
	logic [31:0] sleep_target;
	logic [15:0] sig_half;
	logic cnt_done;

	assign sleep_target = 32'(sleep_value * idle_extension_factor) * 32'(SLEEP_UNIT);

	always_comb begin
		case (bit_rate_range)
			2'd0: sig_half = SIG_HALF0;
			2'd1: sig_half = SIG_HALF1;
			2'd2: sig_half = SIG_HALF2;
			default: sig_half = SIG_HALF3;
		endcase
	end

	// terminal count of the current timed phase
	// >= lets a target lowered mid-phase end the phase at once
	always_comb begin
		case (state_reg)
			RPT_SLEEP: cnt_done = (cnt_reg >= sleep_target);
			RPT_PLL: cnt_done = (cnt_reg >= 32'(PLL_HALF));
			RPT_SIGPROC: cnt_done = (cnt_reg >= 32'(sig_half));
			default: cnt_done = 1'b0;
		endcase
	end

	// phase order, back to sleep on failure
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RPT_IDLE: begin
				if (poll_en) begin
					state_next = RPT_SLEEP;
				end
			end
			RPT_SLEEP: begin
				if (cnt_done) begin
					state_next = RPT_PLL;
				end
			end
			RPT_PLL: begin
				if (cnt_done) begin
					state_next = RPT_SIGPROC;
				end
			end
			RPT_SIGPROC: begin
				if (cnt_done) begin
					state_next = RPT_CHECK;
				end
			end
			RPT_CHECK: begin
				if (chk_done) begin
					state_next = chk_pass ? RPT_RECEIVE : RPT_SLEEP;
				end
			end
			RPT_RECEIVE: begin
				// held until software clears the enable
				state_next = RPT_RECEIVE;
			end
			default: state_next = RPT_IDLE;
		endcase
		// clearing the enable stops polling at any phase
		if (!poll_en) begin
			state_next = RPT_IDLE;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= RPT_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// phase counter: basic ticks in sleep, half ticks in start-ups
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_reg <= 32'h0000_0000;
		end else if (state_next != state_reg) begin
			cnt_reg <= 32'h0000_0000;
		end else if (state_reg == RPT_SLEEP && tick) begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
		end else if ((state_reg == RPT_PLL || state_reg == RPT_SIGPROC) && half_tick) begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
		end
	end

	// check launched on entry to the check phase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chk_start <= 1'b0;
		end else begin
			chk_start <= (state_reg == RPT_SIGPROC) && (state_next == RPT_CHECK);
		end
	end

	// synthesizer powered from its start-up onward
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			synth_enable <= 1'b0;
			sigproc_enable <= 1'b0;
			check_active <= 1'b0;
			signal_found <= 1'b0;
		end else begin
			synth_enable <= (state_next == RPT_PLL) || (state_next == RPT_SIGPROC) ||
				(state_next == RPT_CHECK) || (state_next == RPT_RECEIVE);
			sigproc_enable <= (state_next == RPT_SIGPROC) || (state_next == RPT_CHECK) ||
				(state_next == RPT_RECEIVE);
			check_active <= (state_next == RPT_CHECK);
			signal_found <= (state_next == RPT_RECEIVE);
		end
	end

	// sticky result; set by a pass, cleared when polling is enabled again from idle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			found_reg <= 1'b0;
		end else if (state_reg == RPT_CHECK && chk_done && chk_pass) begin
			found_reg <= 1'b1;
		end else if (state_reg == RPT_IDLE && poll_en) begin
			found_reg <= 1'b0;
		end
	end
endmodule

/* File: verification/rpt_top_properties.sv */
// rpt_top_properties: port-level checks of the polling timebase
// assumes: bound into rpt_top, one clock domain
`timescale 1ns/10ps
module rpt_top_chk #(
	parameter int TICK_DIV = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic synth_enable,
	input wire logic sigproc_enable,
	input wire logic check_active,
	input wire logic signal_found
);
	localparam int PLL_CLKS = 1597 * TICK_DIV / 2;
	int pll_cnt_reg;
	// cycles with the synthesizer on alone; a tick of slack for divider phase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			pll_cnt_reg <= 0;
		else
			pll_cnt_reg <= (synth_enable && !sigproc_enable) ? pll_cnt_reg + 1 : 0;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_req |=> s_ack; endproperty
	property p_unmapped; s_req and !wb_we_i && !(wb_adr_i inside {4'h0, 4'h4, 4'h8}) |=> wb_dat_o == 32'h0;
	endproperty
	property p_pll; $rose(sigproc_enable) |-> pll_cnt_reg inside {[PLL_CLKS - TICK_DIV:PLL_CLKS + TICK_DIV]};
	endproperty
	property p_order; sigproc_enable |-> synth_enable; endproperty
	property p_check; check_active |-> sigproc_enable && !signal_found; endproperty
	property p_found; $rose(signal_found) |-> $past(check_active) && !check_active; endproperty
	property p_fail; $fell(check_active) && !signal_found |-> !synth_enable; endproperty
	property p_hold; signal_found |=> signal_found || !synth_enable; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_pll: assert property (p_pll) else $error("synthesizer start-up length wrong");
	a_order: assert property (p_order) else $error("signal processing without synthesizer");
	a_check: assert property (p_check) else $error("check outside signal processing");
	a_found: assert property (p_found) else $error("found without a check");
	a_fail: assert property (p_fail) else $error("failed check did not sleep");
	a_hold: assert property (p_hold) else $error("receive state left while enabled");
endmodule
bind rpt_top rpt_top_chk #(.TICK_DIV(TICK_DIV)) rpt_top_chk_i (.*);

/* File: verification/rpt_sig_source.sv */
// rpt_sig_source: sliced data stream with fixed edge spacing
// assumes: tee in clocks; zero holds the line low as a silent channel
`timescale 1ns/10ps
module rpt_sig_source (
	input wire logic clk_sys,
	input wire logic [15:0] tee,
	output logic data_in
);
	int cnt = 0;
	initial data_in = 1'b0;
	// toggle after tee clocks, no jitter
	always @(posedge clk_sys) begin
		if (tee == 16'h0) begin
			data_in <= 1'b0;
			cnt <= 0;
		end else if (cnt >= tee - 1) begin
			data_in <= !data_in;
			cnt <= 0;
		end else
			cnt <= cnt + 1;
	end
endmodule

/* File: verification/tb.sv */
// tb: self-checking bench of rpt_top with a data source partner
// assumes: short counts, tick of 2 clocks and sleep unit of 4 ticks
`timescale 1ns/10ps
`include "rpt_cfg.svh"
module tb;
	localparam int TD = 2;
	localparam int SU = 4;
	logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, data_in, chk_d = 0, syn_d = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, synth, sigp, chk, found;
	logic [15:0] tee = 16'h0;
	logic [1:0] nc;
	int mismatches = 0, n_compared = 0, sp_cnt = 0, ck_cnt = 0, sl_cnt = 0;
	int spt[4] = '{930, 546, 354, 258};
	logic [31:0] rd_q[$];
	int sp_q[$], ck_q[$], ckt_q[$], sl_q[$];
	always #10 clk_sys = !clk_sys;
	rpt_top #(.TICK_DIV(TD), .SLEEP_UNIT(SU)) rpt_top_i (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .data_in(data_in), .synth_enable(synth), .sigproc_enable(sigp),
		.check_active(chk), .signal_found(found));
	rpt_sig_source rpt_sig_source_i (.clk_sys(clk_sys), .tee(tee), .data_in(data_in));
	////////////////////////////////////////
	task automatic cmp(input string nm, input int exp, input int tol, input int got);
		n_compared++;
		if (got < exp - tol || got > exp + tol) begin
			mismatches++;
			$display("ERROR %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one classic cycle; the idle edge first keeps strobes apart
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_sys); while (ack !== 1'b1);
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		wb(0, a, $urandom);
	endtask
	task automatic wait_found();
		while (found !== 1'b1) @(posedge clk_sys);
	endtask
	task automatic final_report();
		mismatches += rd_q.size() + sp_q.size() + ck_q.size() + sl_q.size();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	// monitor: oldest note against each result as it shows
	always @(posedge clk_sys) begin
		if (ack === 1'b1 && !we && rd_q.size() > 0) cmp_word("read", rd_q.pop_front(), rdat);
		if (chk === 1'b1 && !chk_d && sp_q.size() > 0) cmp("sigproc", sp_q.pop_front(), TD, sp_cnt);
		if (chk !== 1'b1 && chk_d && ck_q.size() > 0) cmp("check", ck_q.pop_front(), ckt_q.pop_front(), ck_cnt);
		if (synth === 1'b1 && !syn_d && sl_q.size() > 0) cmp("sleep", sl_q.pop_front(), TD, sl_cnt);
		sp_cnt = (sigp === 1'b1 && chk !== 1'b1) ? sp_cnt + 1 : 0;
		ck_cnt = (chk === 1'b1) ? ck_cnt + 1 : 0;
		sl_cnt = (synth === 1'b1) ? 0 : sl_cnt + 1;
		chk_d = chk;
		syn_d = synth;
	end
	// watchdog, well past the expected 20k cycles
	initial begin
		#(20 * 80000);
		mismatches++;
		final_report();
	end
	initial begin
		void'($urandom(41));
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		rd(4'h0, `RPT_CTRL_RST);
		rd(4'h4, `RPT_SLEEP_RST);
		rd(4'h8, 32'h0);
		wr_junk: wb(1, 4'hC, $urandom);
		rd(4'hC, 32'h0);
		// every range with an empty check: start-up lengths
		wb(1, 4'h4, 32'h0);
		for (int r = 0; r < 4; r++) begin
			sp_q.push_back(spt[r] * TD);
			wb(1, 4'h0, {26'h0, 2'h0, 1'($urandom), 2'(r), 1'b1});
			wait_found();
			rd(4'h8, 32'h15);
			wb(1, 4'h0, 32'h0);
		end
		// valid stream; check count code and limit select drawn at random
		tee <= 16'd250;
		nc = 2'(1 + $urandom % 3);
		// 2N intervals plus up to one interval waiting for the first edge
		ck_q.push_back(250 * (12 * nc + 1) / 2);
		ckt_q.push_back(125 + 8 * TD);
		wb(1, 4'h0, {26'h0, nc, 1'($urandom), 2'h3, 1'b1});
		wait_found();
		wb(1, 4'h0, 32'h0);
		// edges too close: check fails fast, cycle sleeps and wakes again
		tee <= 16'd60;
		wb(1, 4'h4, 32'h0302);
		wb(1, 4'h0, 32'h17);
		while (synth !== 1'b1) @(posedge clk_sys);
		// past the first wake-up, so only the sleep after the failed check is noted
		@(posedge clk_sys);
		ck_q.push_back(90);
		ckt_q.push_back(45);
		sl_q.push_back(2 * 3 * SU * TD);
		while (synth === 1'b1) @(posedge clk_sys);
		while (synth !== 1'b1) @(posedge clk_sys);
		cmp_word("found", 32'h0, {31'h0, found});
		repeat (4) @(posedge clk_sys);
		final_report();
	end
endmodule
